// *** common/flash_cmd_regs.vh ***
// Constants for the flash read-mode and command-decode block
// Contract
// - Wrong address, data or order in a command write returns to array read; a wrong first write in autoselect or query mode keeps that mode instead.
// - Command address taken at later falling strobe edge, data at earlier rising edge.
// - Array read after power-up and after embedded program or erase completes.
// - Erase suspend: reads inside suspended sector return status, others array data.
// - Power-on: asynchronous reads, burst clock and address valid ignored.
// - Burst mode follows the configuration enable bit, set and cleared.
// - Hardware reset leaves burst mode alone; only power-on reset ends it.
// - Strobes are asynchronous to burst clock; burst data moves on clock edge.
// - Host gives start address only; device counts following burst addresses.
// - Address valid low one clock loads start address into linear counter.
// - First burst word after initial delay, then one word per configured edge; burst_counter steps once per CLK_I cycle instead.
// - Reset command leaves any command mode to array read with no latency.
// - Reset command keeps secure sector enabled; only its exit command clears it.
// - Autoselect latches bank; reads to other bank return array data.
// - Autoselect returns maker code at XX00h, device ID at XX01h, XX0Eh, XX0Fh.
// - Query 4Fh returns 0001h boot sector flag.
// - Query 50h returns 0001h, program suspend supported.
// - Query 51h returns 0000h write buffer size.
// - Query 57h returns 0002h, two banks.
// - Query 58h..5Bh return 000Fh, 001Fh, 0000h, 0000h sector counts.
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
// ---------------------------------------------------------------
// Command codes and unlock addresses
// ---------------------------------------------------------------
`define CMD_RESET          8'hf0
`define CMD_UNLOCK1        8'haa
`define CMD_UNLOCK2        8'h55
`define CMD_AUTOSEL        8'h90
`define CMD_QUERY          8'h98
`define CMD_SEC_ENTER      8'h88
`define CMD_SEC_EXIT0      8'h00
`define ADDR_UNLOCK1       12'h555
`define ADDR_UNLOCK2       12'h2aa
`define ADDR_QUERY         12'h055
// ---------------------------------------------------------------
// Autoselect offsets
// ---------------------------------------------------------------
`define AS_MAKER           8'h00
`define AS_DEV1            8'h01
`define AS_DEV2            8'h0e
`define AS_DEV3            8'h0f
// ---------------------------------------------------------------
// Query table tail
// ---------------------------------------------------------------
`define Q_BOOT_ADDR        8'h4f
`define Q_BOOT_DATA        32'h0000_0001
`define Q_PSUSP_ADDR       8'h50
`define Q_PSUSP_DATA       32'h0000_0001
`define Q_WBUF_ADDR        8'h51
`define Q_WBUF_DATA        32'h0000_0000
`define Q_BANKS_ADDR       8'h57
`define Q_BANKS_DATA       32'h0000_0002
`define Q_BANK1_ADDR       8'h58
`define Q_BANK1_DATA       32'h0000_000f
`define Q_BANK2_ADDR       8'h59
`define Q_BANK2_DATA       32'h0000_001f
`define Q_BANK3_ADDR       8'h5a
`define Q_BANK4_ADDR       8'h5b
`define Q_ZERO_DATA        32'h0000_0000
// ---------------------------------------------------------------
// Burst configuration reset values
// ---------------------------------------------------------------
`define CFG_LAT_RESET      4'h4
`define CFG_LEN8_RESET     1'b0
`endif

// *** hw/burst_counter.v ***
// Linear burst address counter with initial delay and wrap
`timescale 1ns/1ps
module burst_counter #(
    parameter AW = 20,
    parameter LW = 4
) (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          load_i,
    input  wire [AW-1:0] addr_i,
    input  wire [LW-1:0] lat_i,
    input  wire          len8_i,
    output reg  [AW-1:0] addr_o,
    output reg           valid_o
);
    reg [LW-1:0] wait_cnt;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_o   <= {AW{1'b0}};
            valid_o  <= 1'b0;
            wait_cnt <= {LW{1'b0}};
        end
        else if (load_i)
        begin
            addr_o   <= addr_i;
            valid_o  <= 1'b0;
            wait_cnt <= lat_i;
        end
        else if (wait_cnt != {LW{1'b0}})
        begin
            wait_cnt <= wait_cnt - 1'b1;
            valid_o  <= (wait_cnt == {{(LW-1){1'b0}}, 1'b1});
        end
        else if (valid_o)
        begin
            // Linear wrap within 4 or 8 word block
            if (len8_i)
                addr_o <= {addr_o[AW-1:3], addr_o[2:0] + 3'h1};
            else
                addr_o <= {addr_o[AW-1:2], addr_o[1:0] + 2'h1};
        end
    end
endmodule // burst_counter

// *** hw/flash_cmd_ctrl.v ***
// Read-mode and command-decode logic of a two-bank burst flash
`timescale 1ns/1ps
`include "flash_cmd_regs.vh"
module flash_cmd_ctrl #(
    parameter AW         = 20,
    parameter DW         = 32,
    parameter MAKER_CODE = 32'h0000_005a, // Arbitrary value
    parameter DEV_ID1    = 32'h0000_0011, // Arbitrary value
    parameter DEV_ID2    = 32'h0000_0022, // Arbitrary value
    parameter DEV_ID3    = 32'h0000_0033, // Arbitrary value
    parameter BANK_BIT   = 19
) (
    input  wire          CLK_I,
    input  wire          RST_N_I,
    input  wire          HW_RESET_N_I,
    input  wire          CE_N_I,
    input  wire          WE_N_I,
    input  wire          OE_N_I,
    input  wire          ADDRESS_VALID_N_I,
    input  wire          BURST_CLK_I,
    input  wire [AW-1:0] ADDR_I,
    input  wire [DW-1:0] DATA_I,
    input  wire [DW-1:0] ARRAY_DATA_I,
    input  wire [DW-1:0] STATUS_DATA_I,
    input  wire          EMBED_DONE_I,
    input  wire          ERASE_SUSPEND_I,
    input  wire [AW-1:0] SUSP_SECTOR_BASE_I,
    input  wire [AW-1:0] SUSP_SECTOR_MASK_I,
    input  wire          CFG_WRITE_I,
    input  wire          CFG_BURST_EN_I,
    input  wire [3:0]    CFG_LATENCY_I,
    input  wire          CFG_LEN8_I,
    input  wire          CFG_FALL_EDGE_I,
    output reg  [DW-1:0] DATA_O,
    output reg           DATA_OE_O,
    output reg  [AW-1:0] ARRAY_ADDR_O,
    output reg           BURST_MODE_O,
    output reg           AUTOSELECT_O,
    output reg           QUERY_O,
    output reg           SECURE_SECTOR_O,
    output reg  [1:0]    CMD_STATE_O
);
    // ---------------------------------------------------------------
    // Command states
    // ---------------------------------------------------------------
    localparam ST_READ  = 3'h0;
    localparam ST_UNL1  = 3'h1;
    localparam ST_UNL2  = 3'h2;
    localparam ST_AUTO  = 3'h3;
    localparam ST_QUERY = 3'h4;
    localparam ST_SEXIT = 3'h5;

    reg  [2:0]    state;
    reg  [2:0]    next_state;
    reg           we_q;
    reg           ce_q;
    reg           strobe_on;
    reg  [AW-1:0] cmd_addr;
    reg  [DW-1:0] cmd_data;
    reg           wr_done;
    reg           bank_sel;
    reg           burst_en;
    reg  [3:0]    cfg_lat;
    reg           cfg_len8;
    reg           cfg_fall;
    reg           bclk_q;
    reg           adv_q;
    wire          wr_active;
    wire          burst_edge;
    wire          burst_load;
    wire [AW-1:0] burst_addr;
    wire          burst_valid;

    function is_unlock;
        input [AW-1:0] a;
        input [DW-1:0] d;
        input [11:0]   ea;
        input [7:0]    ed;
        begin
            is_unlock = (a[11:0] == ea) && (d[7:0] == ed);
        end
    endfunction

    function [DW-1:0] query_word;
        input [7:0] a;
        begin
            case (a)
                `Q_BOOT_ADDR:  query_word = `Q_BOOT_DATA;
                `Q_PSUSP_ADDR: query_word = `Q_PSUSP_DATA;
                `Q_WBUF_ADDR:  query_word = `Q_WBUF_DATA;
                `Q_BANKS_ADDR: query_word = `Q_BANKS_DATA;
                `Q_BANK1_ADDR: query_word = `Q_BANK1_DATA;
                `Q_BANK2_ADDR: query_word = `Q_BANK2_DATA;
                `Q_BANK3_ADDR: query_word = `Q_ZERO_DATA;
                `Q_BANK4_ADDR: query_word = `Q_ZERO_DATA;
                default:       query_word = `Q_ZERO_DATA;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // Write strobe latching
    // ---------------------------------------------------------------
    assign wr_active = !we_q && !ce_q;

    always @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            we_q      <= 1'b1;
            ce_q      <= 1'b1;
            strobe_on <= 1'b0;
            cmd_addr  <= {AW{1'b0}};
            cmd_data  <= {DW{1'b0}};
            wr_done   <= 1'b0;
        end
        else
        begin
            we_q    <= WE_N_I;
            ce_q    <= CE_N_I;
            wr_done <= 1'b0;
            if (wr_active && !strobe_on)
            begin
                strobe_on <= 1'b1;
            end
            else if (strobe_on && (we_q || ce_q))
            begin
                strobe_on <= 1'b0;
                wr_done   <= 1'b1;
            end
            // Address at the first cycle with both strobes low, data at the last
            if (!WE_N_I && !CE_N_I && !wr_active)
                cmd_addr <= ADDR_I;
            if (!WE_N_I && !CE_N_I)
                cmd_data <= DATA_I;
        end
    end

    // ---------------------------------------------------------------
    // Command decoder
    // ---------------------------------------------------------------
    always @*
    begin
        next_state = state;
        if (wr_done)
        begin
            case (state)
                ST_READ, ST_AUTO, ST_QUERY:
                begin
                    if (cmd_data[7:0] == `CMD_RESET)
                        next_state = ST_READ;
                    else if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK1, `CMD_UNLOCK1))
                        next_state = ST_UNL1;
                    else if (is_unlock(cmd_addr, cmd_data, `ADDR_QUERY, `CMD_QUERY))
                        next_state = ST_QUERY;
                    else if (state == ST_READ)
                        next_state = ST_READ;
                end
                ST_UNL1:
                begin
                    if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK2, `CMD_UNLOCK2))
                        next_state = ST_UNL2;
                    else
                        next_state = ST_READ;
                end
                ST_UNL2:
                begin
                    if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK1, `CMD_AUTOSEL))
                        next_state = ST_AUTO;
                    else if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK1, `CMD_SEC_ENTER))
                        next_state = ST_READ;
                    else if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK1, `CMD_AUTOSEL) == 1'b0
                             && cmd_data[7:0] == `CMD_AUTOSEL)
                        next_state = ST_SEXIT;
                    else
                        next_state = ST_READ;
                end
                ST_SEXIT:
                    next_state = ST_READ;
                default:
                    next_state = ST_READ;
            endcase
        end
        if (EMBED_DONE_I)
            next_state = ST_READ;
    end

    always @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state           <= ST_READ;
            bank_sel        <= 1'b0;
            SECURE_SECTOR_O <= 1'b0;
        end
        else if (!HW_RESET_N_I)
            state <= ST_READ;
        else
        begin
            state <= next_state;
            if (wr_done && state == ST_UNL2)
            begin
                bank_sel <= cmd_addr[BANK_BIT];
                if (is_unlock(cmd_addr, cmd_data, `ADDR_UNLOCK1, `CMD_SEC_ENTER))
                    SECURE_SECTOR_O <= 1'b1;
            end
            // Only the exit sequence clears the secure sector
            if (wr_done && state == ST_SEXIT && cmd_data[7:0] == `CMD_SEC_EXIT0)
                SECURE_SECTOR_O <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Burst configuration and address phase
    // ---------------------------------------------------------------
    always @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            burst_en <= 1'b0;
            cfg_lat  <= `CFG_LAT_RESET;
            cfg_len8 <= `CFG_LEN8_RESET;
            cfg_fall <= 1'b0;
            bclk_q   <= 1'b0;
            adv_q    <= 1'b1;
        end
        else
        begin
            // Hardware reset pin does not touch burst settings
            if (CFG_WRITE_I)
            begin
                burst_en <= CFG_BURST_EN_I;
                cfg_lat  <= CFG_LATENCY_I;
                cfg_len8 <= CFG_LEN8_I;
                cfg_fall <= CFG_FALL_EDGE_I;
            end
            bclk_q <= BURST_CLK_I;
            if (burst_edge)
                adv_q <= ADDRESS_VALID_N_I;
        end
    end

    assign burst_edge = cfg_fall ? (bclk_q && !BURST_CLK_I) : (!bclk_q && BURST_CLK_I);
    assign burst_load = burst_en && burst_edge && !ADDRESS_VALID_N_I && !CE_N_I;

    burst_counter #(
        .AW (AW),
        .LW (4)
    ) u_burst_counter (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .load_i  (burst_load),
        .addr_i  (ADDR_I),
        .lat_i   (cfg_lat),
        .len8_i  (cfg_len8),
        .addr_o  (burst_addr),
        .valid_o (burst_valid)
    );

    // ---------------------------------------------------------------
    // Read data path
    // ---------------------------------------------------------------
    always @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            DATA_O       <= {DW{1'b0}};
            DATA_OE_O    <= 1'b0;
            ARRAY_ADDR_O <= {AW{1'b0}};
            BURST_MODE_O <= 1'b0;
            AUTOSELECT_O <= 1'b0;
            QUERY_O      <= 1'b0;
            CMD_STATE_O  <= 2'h0;
        end
        else
        begin
            BURST_MODE_O <= burst_en;
            AUTOSELECT_O <= (state == ST_AUTO);
            QUERY_O      <= (state == ST_QUERY);
            CMD_STATE_O  <= state[1:0];
            ARRAY_ADDR_O <= burst_en ? burst_addr : ADDR_I;
            DATA_OE_O    <= !CE_N_I && !OE_N_I && WE_N_I && (!burst_en || burst_valid);
            if (state == ST_AUTO && ADDR_I[BANK_BIT] == bank_sel)
            begin
                case (ADDR_I[7:0])
                    `AS_MAKER: DATA_O <= MAKER_CODE;
                    `AS_DEV1:  DATA_O <= DEV_ID1;
                    `AS_DEV2:  DATA_O <= DEV_ID2;
                    `AS_DEV3:  DATA_O <= DEV_ID3;
                    default:   DATA_O <= {DW{1'b0}};
                endcase
            end
            else if (state == ST_QUERY)
                DATA_O <= query_word(ADDR_I[7:0]);
            else if (ERASE_SUSPEND_I &&
                     ((ADDR_I & SUSP_SECTOR_MASK_I) == SUSP_SECTOR_BASE_I))
                DATA_O <= STATUS_DATA_I;
            else
                DATA_O <= ARRAY_DATA_I;
        end
    end
endmodule // flash_cmd_ctrl

// *** sim/flash_cmd_monitor.sv ***
// Concurrent checks on the ports of the flash read-mode block
`timescale 1ns/1ps
module flash_cmd_monitor #(
    parameter AW = 20,
    parameter DW = 32
) (
    input wire          CLK_I,
    input wire          RST_N_I,
    input wire          HW_RESET_N_I,
    input wire          CE_N_I,
    input wire          WE_N_I,
    input wire          OE_N_I,
    input wire [AW-1:0] ADDR_I,
    input wire [DW-1:0] DATA_I,
    input wire [DW-1:0] ARRAY_DATA_I,
    input wire [DW-1:0] STATUS_DATA_I,
    input wire          ERASE_SUSPEND_I,
    input wire [AW-1:0] SUSP_SECTOR_BASE_I,
    input wire [AW-1:0] SUSP_SECTOR_MASK_I,
    input wire          CFG_WRITE_I,
    input wire          CFG_BURST_EN_I,
    input wire [DW-1:0] DATA_O,
    input wire          DATA_OE_O,
    input wire [AW-1:0] ARRAY_ADDR_O,
    input wire          BURST_MODE_O,
    input wire          AUTOSELECT_O,
    input wire          QUERY_O,
    input wire          SECURE_SECTOR_O
);
    wire rd   = !CE_N_I && !OE_N_I && WE_N_I;
    wire pl   = !BURST_MODE_O && !AUTOSELECT_O && !QUERY_O && !SECURE_SECTOR_O;
    wire insc = ERASE_SUSPEND_I && (ADDR_I & SUSP_SECTOR_MASK_I) == SUSP_SECTOR_BASE_I;
    wire tail = ADDR_I[7:0] inside {8'h4f, 8'h50, 8'h51, [8'h57:8'h5b]};
    reg  f0w;
    function [DW-1:0] qv(input [AW-1:0] a);
        qv = (a[7:0] == 8'h4f || a[7:0] == 8'h50) ? 32'h1 : a[7:0] == 8'h57 ? 32'h2 :
             a[7:0] == 8'h58 ? 32'hf : a[7:0] == 8'h59 ? 32'h1f : 32'h0;
    endfunction
    // Marks a strobe-low cycle that carries the reset command
    always @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            f0w <= 1'b0;
        else
            f0w <= !CE_N_I && !WE_N_I && DATA_I[7:0] == 8'hf0;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    burst_enter_a: assert property (CFG_WRITE_I && CFG_BURST_EN_I |-> ##[1:3] BURST_MODE_O)
        else $error("burst mode not entered");
    burst_exit_a: assert property (CFG_WRITE_I && !CFG_BURST_EN_I |-> ##[1:3] !BURST_MODE_O)
        else $error("burst mode not left");
    hw_keep_a: assert property (BURST_MODE_O && !HW_RESET_N_I && !CFG_WRITE_I |=> BURST_MODE_O)
        else $error("hardware reset ended burst mode");
    async_addr_a: assert property (!BURST_MODE_O ##1 !BURST_MODE_O |-> ARRAY_ADDR_O == $past(ADDR_I))
        else $error("async address not passed");
    array_read_a: assert property (rd && pl && !insc |=> DATA_OE_O && DATA_O == $past(ARRAY_DATA_I))
        else $error("array read wrong");
    susp_status_a: assert property (rd && pl && insc |=> DATA_O == $past(STATUS_DATA_I))
        else $error("suspended sector read wrong");
    query_tail_a: assert property (
        rd && QUERY_O && tail |=> DATA_O == qv($past(ADDR_I)))
        else $error("query value wrong");
    reset_cmd_a: assert property (f0w && WE_N_I |-> ##[1:4] (!AUTOSELECT_O && !QUERY_O))
        else $error("reset command ignored");
    secure_keep_a: assert property (f0w && WE_N_I && SECURE_SECTOR_O |-> SECURE_SECTOR_O [*5])
        else $error("secure sector dropped");
    oe_cause_a: assert property (DATA_OE_O |-> $past(rd))
        else $error("output enable without read");
    cover property (BURST_MODE_O && DATA_OE_O);
    cover property (rd && AUTOSELECT_O);
    cover property (rd && QUERY_O && tail);
    cover property (rd && pl && insc);
endmodule // flash_cmd_monitor
bind flash_cmd_ctrl flash_cmd_monitor #(.AW(AW), .DW(DW)) flash_cmd_monitor_inst (.*);

// *** sim/flash_host_model.sv ***
// Host bus model driving strobes, address, data and burst clock
`timescale 1ns/1ps
module flash_host_model (
    input  wire        clk_i,
    output reg         ce_n_o,
    output reg         we_n_o,
    output reg         oe_n_o,
    output reg         adv_n_o,
    output reg         bclk_o,
    output reg  [19:0] addr_o,
    output reg  [31:0] data_o
);
    reg       bon;
    reg [1:0] bcnt;
    initial
    begin
        {ce_n_o, we_n_o, oe_n_o, adv_n_o, bclk_o, bon, bcnt} = 8'hf0;
        addr_o = 20'h0;
        data_o = 32'h0;
    end
    // Burst clock runs only while a burst is open
    always @(posedge clk_i)
    begin
        bcnt   <= bon ? bcnt + 2'd1 : 2'd0;
        bclk_o <= bon & bcnt[1];
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task step;
    begin
        @(posedge clk_i);
        #2;
    end
    endtask
    task cmd_write(input [19:0] a, input [31:0] d);
    begin
        addr_o = a;
        data_o = d;
        {ce_n_o, we_n_o} = 2'b00;
        repeat (2) step;
        {ce_n_o, we_n_o} = 2'b11;
        step;
        addr_o = ~a;
        data_o = ~d;
        repeat (3) step;
    end
    endtask
    task read_on(input [19:0] a);
    begin
        addr_o = a;
        {ce_n_o, oe_n_o} = 2'b00;
        step;
    end
    endtask
    task read_off;
    begin
        {ce_n_o, oe_n_o} = 2'b11;
        addr_o = ~addr_o;
        step;
    end
    endtask
    task burst_open(input [19:0] a);
    begin
        addr_o = a;
        {ce_n_o, oe_n_o, adv_n_o} = 3'b000;
        bon = 1'b1;
        repeat (6) step;
        adv_n_o = 1'b1;
        addr_o = ~a;
    end
    endtask
    task burst_close;
    begin
        bon = 1'b0;
        {ce_n_o, oe_n_o} = 2'b11;
        step;
    end
    endtask
endmodule // flash_host_model

// *** sim/test_flash_cmd_ctrl.sv ***
// Self-checking bench for the flash read-mode and command block
`timescale 1ns/1ps
module test_flash_cmd_ctrl;
    reg         clk, rst_n, hw_n, susp, cfg_wr, cfg_en, embed;
    reg  [31:0] arr, sts;
    reg  [19:0] sb, p;
    wire        ce_n, we_n, oe_n, adv_n, bclk, doe, bm, as_o, q_o, sec;
    wire [19:0] addr, aa;
    wire [31:0] din, dout;
    integer     mismatches, samples_checked, asm, qm, i, n;
    flash_cmd_ctrl flash_cmd_ctrl_inst (.CLK_I(clk), .RST_N_I(rst_n), .HW_RESET_N_I(hw_n), .CE_N_I(ce_n),
        .WE_N_I(we_n), .OE_N_I(oe_n), .ADDRESS_VALID_N_I(adv_n), .BURST_CLK_I(bclk), .ADDR_I(addr),
        .DATA_I(din), .ARRAY_DATA_I(arr), .STATUS_DATA_I(sts), .EMBED_DONE_I(embed), .ERASE_SUSPEND_I(susp),
        .SUSP_SECTOR_BASE_I(sb), .SUSP_SECTOR_MASK_I(20'hf0000), .CFG_WRITE_I(cfg_wr), .CFG_BURST_EN_I(cfg_en),
        .CFG_LATENCY_I(4'h4), .CFG_LEN8_I(1'b0), .CFG_FALL_EDGE_I(1'b0), .DATA_O(dout), .DATA_OE_O(doe),
        .ARRAY_ADDR_O(aa), .BURST_MODE_O(bm), .AUTOSELECT_O(as_o), .QUERY_O(q_o), .SECURE_SECTOR_O(sec),
        .CMD_STATE_O());
    flash_host_model flash_host_model_inst (.clk_i(clk), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n),
        .adv_n_o(adv_n), .bclk_o(bclk), .addr_o(addr), .data_o(din));
    // ----------------------------------------
    // Helpers and reference model
    // ----------------------------------------
    task st;
        flash_host_model_inst.step;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
        end
    end
    endtask
    task cw(input [11:0] a, input [7:0] d);
        flash_host_model_inst.cmd_write({8'h00, a}, {24'h0, d});
    endtask
    function [31:0] model(input [19:0] a);
    begin
        model = (susp && (a & 20'hf0000) == sb) ? sts : arr;
        if (qm)
            model = (a[7:0] == 8'h4f || a[7:0] == 8'h50) ? 32'h1 : a[7:0] == 8'h57 ? 32'h2 :
                a[7:0] == 8'h58 ? 32'hf : a[7:0] == 8'h59 ? 32'h1f : 32'h0;
        if (asm && !a[19])
            model = a[7:0] == 8'h00 ? 32'h5a : a[7:0] == 8'h01 ? 32'h11 : a[7:0] == 8'h0e ? 32'h22 : 32'h33;
    end
    endfunction
    task rd(input [19:0] a);
    begin
        arr = $urandom;
        sts = $urandom;
        flash_host_model_inst.read_on(a);
        chk(dout, model(a));
        chk({12'h0, aa}, {12'h0, a});
        flash_host_model_inst.read_off;
    end
    endtask
    task cfg(input en);
    begin
        cfg_en = en;
        cfg_wr = 1'b1;
        st;
        cfg_wr = 1'b0;
        repeat (3) st;
        chk({31'h0, bm}, {31'h0, en});
    end
    endtask
    task give_verdict;
    begin
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #500000;
        mismatches = mismatches + 1;
        give_verdict;
    end
    initial
    begin
        {rst_n, hw_n, susp, cfg_wr, cfg_en, embed} = 6'b010000;
        {arr, sts, sb} = 84'h0;
        {mismatches, samples_checked, asm, qm} = 128'h0;
        n = $urandom(42038);
        repeat (16) st;
        rst_n = 1'b1;
        chk({31'h0, bm}, 32'h0);
        repeat (2) st;
        for (i = 0; i < 4; i = i + 1)
            rd(20'($urandom) & 20'h7ffff);
        cw(12'h555, 8'haa);
        cw(12'h2aa, 8'h55);
        cw(12'h555, 8'h90);
        asm = 1;
        for (i = 0; i < 4; i = i + 1)
            rd(i == 0 ? 20'h0 : i == 1 ? 20'h1 : i == 2 ? 20'he : 20'hf);
        rd(20'h80001);
        cw(12'h000, 8'hf0);
        asm = 0;
        rd(20'h00001);
        for (i = 0; i < 2; i = i + 1)
        begin
            cw(12'h555, 8'haa);
            cw(i ? 12'h123 : 12'h2aa, i ? 8'h55 : 8'h12);
            cw(12'h555, 8'h90);
            chk({31'h0, as_o}, 32'h0);
        end
        cw(12'h555, 8'haa);
        cw(12'h2aa, 8'h55);
        cw(12'h555, 8'h90);
        chk({31'h0, as_o}, 32'h1);
        embed = 1'b1;
        st;
        embed = 1'b0;
        repeat (2) st;
        chk({31'h0, as_o}, 32'h0);
        cw(12'h055, 8'h98);
        qm = 1;
        for (i = 8'h4f; i <= 8'h5b; i = i + 1)
            if (i < 8'h52 || i > 8'h56)
                rd(i[19:0]);
        cw(12'h000, 8'hf0);
        qm = 0;
        chk({31'h0, q_o}, 32'h0);
        cw(12'h555, 8'haa);
        cw(12'h2aa, 8'h55);
        cw(12'h555, 8'h88);
        cw(12'h000, 8'hf0);
        chk({31'h0, sec}, 32'h1);
        cw(12'h555, 8'haa);
        cw(12'h2aa, 8'h55);
        cw(12'h000, 8'h90);
        cw(12'h000, 8'h00);
        chk({31'h0, sec}, 32'h0);
        susp = 1'b1;
        sb = 20'h10000;
        rd(20'h12345);
        rd(20'h22345);
        susp = 1'b0;
        cfg(1'b1);
        flash_host_model_inst.burst_open(20'h00106);
        n = 0;
        while (doe !== 1'b1 && n < 100)
        begin
            st;
            n = n + 1;
        end
        chk({31'h0, doe}, 32'h1);
        chk({12'h0, aa & 20'hffffc}, 32'h104);
        p = aa;
        for (i = 0; i < 7; i = i + 1)
        begin
            st;
            chk({12'h0, aa}, {12'h0, p[19:2], p[1:0] + 2'd1});
            p = aa;
        end
        flash_host_model_inst.burst_close;
        hw_n = 1'b0;
        repeat (2) st;
        hw_n = 1'b1;
        st;
        chk({31'h0, bm}, 32'h1);
        cfg(1'b0);
        cfg(1'b1);
        rst_n = 1'b0;
        st;
        rst_n = 1'b1;
        st;
        chk({31'h0, bm}, 32'h0);
        give_verdict;
    end
endmodule // test_flash_cmd_ctrl
